// >>> hdl/isa14_instruction_decoder.sv
// isa14_instruction_decoder: executes 14-bit instruction words handed in over APB.
// assumes an APB master on pclk; port_pins are asynchronous and get synchronised here.
//
// Summary of operation
// RULE1: flags produced by an instruction override bits it writes into the status register.
// RULE2: reading pc low byte returns it; writing loads high byte from holding latch.
// RULE3: read-modify-write on pc low byte uses it as operand, result reloads the counter.
// RULE4: bit set and clear read the whole byte and write the whole byte back; bit tests only read it.
// RULE5: the port register used as its own operand reads the pin levels, not the latch.
// RULE6: writing the timer count clears the prescaler when it is assigned to the timer.
// RULE7: a taken skip or a counter change costs a second, empty instruction cycle.
// RULE8: byte format: prefix, 4-bit op, destination bit, 7-bit address; logic and arithmetic flags.
// RULE9: rotates through carry touch only carry; nibble swap touches no flag.
// RULE10: decrement and increment variants skip the next instruction when the result is zero.
// RULE11: bit format: clear, set, skip if clear, skip if set; no flag changes.
// RULE12: literal or, xor and and on the accumulator update only the zero flag.
// RULE13: literal minus and plus accumulator update all flags; literal load changes none.
// RULE14: return with literal loads the accumulator, returns, takes two cycles.
// RULE15: standby and watchdog clear words are single cycle and set timeout; watchdog clear sets powerdown, standby clears it.
// RULE16: destination bit zero writes the accumulator, one writes the addressed register.
// RULE17: each instruction cycle spans four clock periods.
// RULE18: jump prefix carries an 11-bit target; following bit zero calls, one jumps.
// RULE19: fixed control words match exactly on all non-operand bits; the no-operation word here ignores bits 6:5 (NOP_MASK).
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module isa14_instruction_decoder (
	input wire logic pclk,
	input wire logic presetn,
	input wire isa14_pkg::isa14_apb_req_type apb_req,
	output isa14_pkg::isa14_apb_resp_type apb_resp,
	input wire logic [7:0] port_pins,
	output logic [7:0] port_out,
	output logic standby,
	output logic watchdog_clear
);
	import isa14_pkg::*;

	localparam isa14_core_type CORE_RESET = '{state: ST_IDLE, status: STATUS_RESET, default: '0};
	localparam logic [13:0] WORD_CLEAR_REG_STATUS = 14'h0183;
	localparam logic [13:0] WORD_MOVE_ACCUM_TO_REG_PCL = 14'h0082;
	localparam logic [13:0] WORD_MOVE_ACCUM_TO_REG_TIMER_ZERO_COUNT = 14'h0081;
	localparam logic [13:0] WORD_MOVE_REG_PORT = 14'h0886;

	isa14_core_type r, n;
	logic tick, commit, busy, jump, skip, wr_f, wr_w, arith, bad, push, pop;
	logic upd_c, upd_dc, upd_z, new_c;
	logic [7:0] opnd, res, ptop;
	logic [9:0] alu;
	logic [12:0] pc_load;
	logic [6:0] fa;
	logic [2:0] bsel;
	logic [31:0] rdata;

	function automatic logic in_gpr(input logic [6:0] a);
		return (a >= GPR_BASE) && (a < GPR_BASE + 7'(GPR_COUNT));
	endfunction

	function automatic logic [7:0] read_file(input logic [6:0] a, input isa14_core_type s);
		if (a == ADDR_TIMER_ZERO_COUNT) begin
			return s.timer_zero_count;
		end else if (a == ADDR_PCL) begin
			return s.pc[7:0]; // see RULE2 see RULE3
		end else if (a == ADDR_STATUS) begin
			return s.status;
		end else if (a == ADDR_PORT) begin
			return s.pins; // see RULE5
		end else if (a == ADDR_PC_HIGH_HOLDING_LATCH) begin
			return {3'h0, s.pc_high_holding_latch};
		end else if (in_gpr(a)) begin
			return s.gpr[4'(a - GPR_BASE)];
		end
		return 8'h00;
	endfunction

	// {carry, digit carry, sum}; subtraction passes the inverted operand with carry in set
	function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
		logic [4:0] lo;
		logic [8:0] full;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		return {full[8], lo[4], full[7:0]};
	endfunction

	assign tick = (r.phase == PHASE_LAST);
	assign commit = tick && (r.state == ST_EXEC);
	assign busy = (r.state != ST_IDLE);
	assign apb_resp = r.resp;
	assign port_out = r.port_latch;
	assign standby = r.sleeping;
	assign watchdog_clear = r.wdt_clear;

	always_comb begin
		n = r;
		fa = r.instr[6:0];
		bsel = r.instr[9:7];
		opnd = read_file(fa, r);
		res = opnd;
		alu = '0;
		rdata = '0;
		{wr_f, wr_w, arith, bad, push, pop, jump, skip, upd_c, upd_dc, upd_z} = '0;
		new_c = r.status[BIT_C];
		pc_load = r.pc;
		n.wdt_clear = 1'b0;
		n.phase = r.phase + 2'h1; // see RULE17
		// a pin change is taken only once the last two stages agree
		n.pin_sync = {r.pin_sync[1:0], port_pins};
		for (int i = 0; i < 8; i++) begin
			if (r.pin_sync[1][i] == r.pin_sync[2][i]) begin
				n.pins[i] = r.pin_sync[2][i];
			end
		end
		ptop = (8'h02 << r.tcfg[3:1]) - 8'h01;
		if (tick && !r.sleeping) begin
			if (r.tcfg[TCFG_PSA]) begin
				n.prescaler = r.prescaler + 8'h01;
				if ((r.prescaler & ptop) == ptop) begin
					n.timer_zero_count = r.timer_zero_count + 8'h01;
				end
			end else begin
				n.timer_zero_count = r.timer_zero_count + 8'h01;
			end
		end

		// apb: one wait state, the answer is computed a cycle before pready
		n.resp.pready = 1'b0;
		if (apb_req.psel && apb_req.penable && !r.resp.pready) begin
			n.resp.pready = 1'b1;
			n.resp.pslverr = 1'b0;
			if (apb_req.paddr == OFS_INSTR) begin
				rdata = {18'h0, r.instr};
				n.resp.pslverr = apb_req.pwrite && busy;
			end else if (apb_req.paddr == OFS_ACCUM) begin
				rdata = {24'h0, r.accum};
				n.resp.pslverr = apb_req.pwrite && busy;
			end else if (apb_req.paddr == OFS_CORE_STATUS) begin
				rdata = {16'h0, r.status, 4'h0, r.illegal, r.gie, r.sleeping, busy};
			end else if (apb_req.paddr == OFS_PROG_COUNTER) begin
				rdata = {19'h0, r.pc};
			end else if (apb_req.paddr == OFS_TIMER_CFG) begin
				rdata = {8'h0, r.prescaler, r.timer_zero_count, 4'h0, r.tcfg};
			end else if (apb_req.paddr == OFS_PORT_VIEW) begin
				rdata = {16'h0, r.pins, r.port_latch};
			end else begin
				n.resp.pslverr = 1'b1;
			end
			n.resp.prdata = rdata;
		end
		if (apb_req.psel && apb_req.penable && r.resp.pready && apb_req.pwrite && !r.resp.pslverr) begin
			if (apb_req.paddr == OFS_INSTR) begin
				n.instr = apb_req.pwdata[13:0];
				n.state = ST_LOADED;
				n.sleeping = 1'b0;
			end else if (apb_req.paddr == OFS_ACCUM) begin
				n.accum = apb_req.pwdata[7:0];
			end else if (apb_req.paddr == OFS_TIMER_CFG) begin
				n.tcfg = apb_req.pwdata[3:0];
			end
		end

		if (tick && r.state == ST_LOADED) begin
			n.state = ST_EXEC;
		end else if (tick && r.state == ST_FLUSH) begin
			n.state = ST_IDLE;
		end

		if (commit) begin
			case (r.instr[13:12])
				PFX_BYTE: begin
					wr_f = r.instr[7]; // see RULE8 see RULE16
					wr_w = !r.instr[7];
					case (r.instr[11:8])
						OP_MISC: begin
							res = r.accum;
							wr_w = 1'b0;
							if (!r.instr[7]) begin
								if (r.instr == WORD_RETURN || r.instr == WORD_RETURN_FROM_IRQ) begin
									pop = 1'b1; // see RULE19
									n.gie = r.gie || (r.instr == WORD_RETURN_FROM_IRQ);
								end else if (r.instr == WORD_SLEEP) begin
									n.status[BIT_TO] = 1'b1; // see RULE15
									n.status[BIT_PD] = 1'b0;
									n.sleeping = 1'b1;
								end else if (r.instr == WORD_WATCHDOG_CLEAR) begin
									n.status[BIT_TO] = 1'b1; // see RULE15
									n.status[BIT_PD] = 1'b1;
									n.wdt_clear = 1'b1;
								end else if ((r.instr & NOP_MASK) != WORD_NOP) begin
									bad = 1'b1; // see RULE19
								end
							end
						end
						OP_CLR: begin
							res = 8'h00;
							upd_z = 1'b1;
							if (!r.instr[7] && r.instr != WORD_CLEAR_ACCUM) begin
								{bad, wr_w, upd_z} = 3'b100; // see RULE19
							end
						end
						OP_SUB: begin
							alu = add8(opnd, ~r.accum, 1'b1);
							arith = 1'b1;
						end
						OP_ADD: begin
							alu = add8(opnd, r.accum, 1'b0);
							arith = 1'b1;
						end
						OP_DEC: {upd_z, res} = {1'b1, opnd - 8'h01};
						OP_INC: {upd_z, res} = {1'b1, opnd + 8'h01};
						OP_IOR: {upd_z, res} = {1'b1, opnd | r.accum}; // see RULE8
						OP_AND: {upd_z, res} = {1'b1, opnd & r.accum};
						OP_XOR: {upd_z, res} = {1'b1, opnd ^ r.accum};
						OP_MOV: upd_z = 1'b1;
						OP_COM: {upd_z, res} = {1'b1, ~opnd};
						OP_RRC: {upd_c, new_c, res} = {1'b1, opnd[0], r.status[BIT_C], opnd[7:1]}; // see RULE9
						OP_RLC: {upd_c, new_c, res} = {1'b1, opnd[7], opnd[6:0], r.status[BIT_C]};
						OP_SWAP: res = {opnd[3:0], opnd[7:4]};
						OP_DECSZ: begin
							res = opnd - 8'h01; // see RULE10
							skip = (res == 8'h00);
						end
						default: begin
							res = opnd + 8'h01;
							skip = (res == 8'h00);
						end
					endcase
				end
				PFX_BIT: begin
					res = opnd; // see RULE4 see RULE11
					case (r.instr[11:10])
						2'b00: {wr_f, res[bsel]} = 2'b10;
						2'b01: {wr_f, res[bsel]} = 2'b11;
						2'b10: skip = !opnd[bsel];
						default: skip = opnd[bsel];
					endcase
				end
				PFX_JUMP: begin
					jump = 1'b1; // see RULE18
					push = !r.instr[11];
					pc_load = {r.pc_high_holding_latch[4:3], r.instr[10:0]};
				end
				default: begin
					res = r.instr[7:0];
					wr_w = 1'b1;
					case (r.instr[11:10])
						2'b00: ; // see RULE13
						2'b01: pop = 1'b1; // see RULE14
						2'b10: begin
							upd_z = 1'b1; // see RULE12
							case (r.instr[9:8])
								2'b00: res = r.instr[7:0] | r.accum;
								2'b01: res = r.instr[7:0] & r.accum;
								2'b10: res = r.instr[7:0] ^ r.accum;
								default: {bad, wr_w, upd_z} = 3'b100;
							endcase
						end
						default: begin
							arith = 1'b1; // see RULE13
							alu = r.instr[9] ? add8(r.accum, r.instr[7:0], 1'b0) : add8(r.instr[7:0], ~r.accum, 1'b1);
						end
					endcase
				end
			endcase

			if (arith) begin
				{upd_c, upd_dc, upd_z, new_c} = {3'b111, alu[9]};
				res = alu[7:0];
			end
			if (pop) begin
				jump = 1'b1;
				pc_load = r.stack[3'(r.sp - 3'h1)];
				n.sp = r.sp - 3'h1;
			end
			if (push) begin
				n.stack[r.sp] = r.pc + PC_STEP;
				n.sp = r.sp + 3'h1;
			end
			if (wr_f) begin
				if (fa == ADDR_TIMER_ZERO_COUNT) begin
					n.timer_zero_count = res;
					if (r.tcfg[TCFG_PSA]) begin
						n.prescaler = 8'h00; // see RULE6
					end
				end else if (fa == ADDR_PCL) begin
					pc_load = {r.pc_high_holding_latch, res}; // see RULE2 see RULE3
					jump = 1'b1;
				end else if (fa == ADDR_STATUS) begin
					n.status = (res & STATUS_WR_MASK) | (r.status & ~STATUS_WR_MASK);
				end else if (fa == ADDR_PORT) begin
					n.port_latch = res;
				end else if (fa == ADDR_PC_HIGH_HOLDING_LATCH) begin
					n.pc_high_holding_latch = res[4:0];
				end else if (in_gpr(fa)) begin
					n.gpr[4'(fa - GPR_BASE)] = res;
				end
			end
			// flags land after the register write so they win over written bits
			if (upd_z) begin
				n.status[BIT_Z] = (res == 8'h00); // see RULE1
			end
			if (upd_c) begin
				n.status[BIT_C] = new_c;
			end
			if (upd_dc) begin
				n.status[BIT_DC] = alu[8];
			end
			if (wr_w) begin
				n.accum = res; // see RULE16
			end
			n.illegal = bad;
			n.pc = jump ? pc_load : r.pc + (skip ? PC_SKIP : PC_STEP);
			n.state = (jump || skip) ? ST_FLUSH : ST_IDLE; // see RULE7
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= CORE_RESET;
		end else begin
			r <= n;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	status_override_a: assert property (commit && r.instr == WORD_CLEAR_REG_STATUS |=> r.status[2:0] == 3'b100) // see RULE1
		else $error("status flags not overriding written value");
	pcl_write_a: assert property (commit && r.instr == WORD_MOVE_ACCUM_TO_REG_PCL |=> r.pc == {$past(r.pc_high_holding_latch), $past(r.accum)}) // see RULE2
		else $error("pc low byte write did not reload counter");
	bit_rmw_a: assert property (commit && r.instr[13:10] == 4'h5 && fa == GPR_BASE // see RULE4
		|=> r.gpr[0] == ($past(r.gpr[0]) | (8'h01 << $past(bsel))))
		else $error("bit set altered other bits");
	port_pins_a: assert property (commit && r.instr == WORD_MOVE_REG_PORT |=> r.port_latch == $past(r.pins)) // see RULE5
		else $error("port rewrite did not use pin levels");
	prescaler_clear_a: assert property (commit && r.instr == WORD_MOVE_ACCUM_TO_REG_TIMER_ZERO_COUNT && r.tcfg[TCFG_PSA] // see RULE6
		|=> r.prescaler == 8'h00 && r.timer_zero_count == $past(r.accum))
		else $error("timer write did not clear prescaler");
	two_cycle_a: assert property (commit && r.instr[13:12] == PFX_JUMP // see RULE7
		|=> (r.state == ST_FLUSH) [*4] ##1 r.state == ST_IDLE)
		else $error("jump did not take one empty cycle");
	skip_zero_a: assert property (commit && r.instr[13:8] == {PFX_BYTE, OP_DECSZ} && opnd == 8'h01 // see RULE10
		|=> r.state == ST_FLUSH && r.pc == $past(r.pc) + PC_SKIP)
		else $error("zero result did not skip");
	add_dest_a: assert property (commit && r.instr[13:7] == {PFX_BYTE, OP_ADD, 1'b0} && fa == GPR_BASE // see RULE16
		|=> r.accum == 8'($past(r.accum) + $past(r.gpr[0])) && r.gpr[0] == $past(r.gpr[0]))
		else $error("add to accumulator wrong");
	standby_a: assert property (commit && r.instr == WORD_SLEEP // see RULE15
		|=> standby && r.status[BIT_TO] && !r.status[BIT_PD] && r.state == ST_IDLE)
		else $error("standby entry wrong");
	cycle_len_a: assert property ($rose(r.state == ST_EXEC) |-> (r.state == ST_EXEC) [*4] ##1 r.state != ST_EXEC) // see RULE17
		else $error("instruction cycle not four clocks");
	apb_answer_a: assert property (apb_req.psel && apb_req.penable && !r.resp.pready |=> apb_resp.pready)
		else $error("apb answer late");
endmodule

// >>> hdl/isa14_pkg.sv
// isa14_pkg: constants, encodings and carrier types of the 14-bit instruction decoder.
// assumes one clock (pclk) and an APB master with an 8-bit byte address.
package isa14_pkg;
	localparam int GPR_COUNT = 16;
	localparam int STACK_DEPTH = 8;
	localparam int CYCLE_PHASES = 4;
	localparam logic [1:0] PHASE_LAST = 2'(CYCLE_PHASES - 1);
	localparam logic [7:0] OFS_INSTR = 8'h00;
	localparam logic [7:0] OFS_ACCUM = 8'h04;
	localparam logic [7:0] OFS_CORE_STATUS = 8'h08;
	localparam logic [7:0] OFS_PROG_COUNTER = 8'h0C;
	localparam logic [7:0] OFS_TIMER_CFG = 8'h10;
	localparam logic [7:0] OFS_PORT_VIEW = 8'h14;
	localparam logic [6:0] ADDR_TIMER_ZERO_COUNT = 7'h01;
	localparam logic [6:0] ADDR_PCL = 7'h02;
	localparam logic [6:0] ADDR_STATUS = 7'h03;
	localparam logic [6:0] ADDR_PORT = 7'h06;
	localparam logic [6:0] ADDR_PC_HIGH_HOLDING_LATCH = 7'h0A;
	localparam logic [6:0] GPR_BASE = 7'h20;
	localparam int BIT_C = 0;
	localparam int BIT_DC = 1;
	localparam int BIT_Z = 2;
	localparam int BIT_PD = 3;
	localparam int BIT_TO = 4;
	localparam int TCFG_PSA = 0;
	localparam logic [7:0] STATUS_RESET = 8'h18;
	localparam logic [7:0] STATUS_WR_MASK = 8'hE7;
	localparam logic [1:0] PFX_BYTE = 2'h0;
	localparam logic [1:0] PFX_BIT = 2'h1;
	localparam logic [1:0] PFX_JUMP = 2'h2;
	localparam logic [1:0] PFX_LIT = 2'h3;
	localparam logic [3:0] OP_MISC = 4'h0;
	localparam logic [3:0] OP_CLR = 4'h1;
	localparam logic [3:0] OP_SUB = 4'h2;
	localparam logic [3:0] OP_DEC = 4'h3;
	localparam logic [3:0] OP_IOR = 4'h4;
	localparam logic [3:0] OP_AND = 4'h5;
	localparam logic [3:0] OP_XOR = 4'h6;
	localparam logic [3:0] OP_ADD = 4'h7;
	localparam logic [3:0] OP_MOV = 4'h8;
	localparam logic [3:0] OP_COM = 4'h9;
	localparam logic [3:0] OP_INC = 4'hA;
	localparam logic [3:0] OP_DECSZ = 4'hB;
	localparam logic [3:0] OP_RRC = 4'hC;
	localparam logic [3:0] OP_RLC = 4'hD;
	localparam logic [3:0] OP_SWAP = 4'hE;
	localparam logic [3:0] OP_INCSZ = 4'hF;
	localparam logic [13:0] WORD_RETURN = 14'h0008;
	localparam logic [13:0] WORD_RETURN_FROM_IRQ = 14'h0009;
	localparam logic [13:0] WORD_SLEEP = 14'h0063;
	localparam logic [13:0] WORD_WATCHDOG_CLEAR = 14'h0064;
	localparam logic [13:0] WORD_CLEAR_ACCUM = 14'h0103;
	localparam logic [13:0] WORD_NOP = 14'h0000;
	localparam logic [13:0] NOP_MASK = 14'h3F9F;
	localparam logic [12:0] PC_STEP = 13'h0001;
	localparam logic [12:0] PC_SKIP = 13'h0002;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_LOADED = 2'b01, ST_EXEC = 2'b10, ST_FLUSH = 2'b11} isa14_state_type;
	typedef struct packed {
		logic [7:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} isa14_apb_req_type;
	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} isa14_apb_resp_type;
	typedef struct packed {
		isa14_state_type state;
		logic [1:0] phase;
		logic [13:0] instr;
		logic [7:0] accum;
		logic [7:0] status;
		logic [12:0] pc;
		logic [4:0] pc_high_holding_latch;
		logic [7:0] timer_zero_count;
		logic [7:0] prescaler;
		logic [3:0] tcfg;
		logic [7:0] port_latch;
		logic [2:0][7:0] pin_sync;
		logic [7:0] pins;
		logic [GPR_COUNT-1:0][7:0] gpr;
		logic [STACK_DEPTH-1:0][12:0] stack;
		logic [2:0] sp;
		logic gie;
		logic sleeping;
		logic illegal;
		logic wdt_clear;
		isa14_apb_resp_type resp;
	} isa14_core_type;
endpackage

// >>> testbench/isa14_instruction_decoder_test.sv
// isa14_instruction_decoder_test: self-checking bench for the instruction decoder.
// assumes APB answers with one wait state and an instruction is done 16 clocks after the read that follows its write.
`timescale 1ns/100ps
module isa14_instruction_decoder_test;
	import isa14_pkg::*;
	typedef struct packed {logic [31:0] exp; logic [31:0] mask; logic err;} isa14_note_type;
	logic pclk;
	logic presetn;
	isa14_apb_req_type req;
	isa14_apb_resp_type resp;
	logic [7:0] port_pins;
	logic [7:0] port_out;
	logic standby;
	logic watchdog_clear;
	isa14_note_type notes[$];
	isa14_note_type nt;
	int errors = 0;
	int check_count = 0;
	int cycles = 0;
	int pulses = 0;
	integer seed = 32'h98703BAB;
	logic [31:0] rn;
	logic [3:0] op;
	logic [1:0] c;
	logic [2:0] b;
	logic [2:0] fl;
	logic d, tk;
	logic [6:0] a;
	logic [7:0] fv, r, w;
	logic [12:0] pc, ret;
	logic [5:0] lp [9] = '{6'h38, 6'h3A, 6'h39, 6'h3C, 6'h3D, 6'h3E, 6'h3F, 6'h30, 6'h33};
	logic [3:0] lo [9] = '{OP_IOR, OP_XOR, OP_AND, OP_SUB, OP_SUB, OP_ADD, OP_ADD, OP_MOV, OP_MOV};
	logic [13:0] rws [3] = '{14'h3577, WORD_RETURN, WORD_RETURN_FROM_IRQ};

	isa14_instruction_decoder u_dut (
		.pclk(pclk),
		.presetn(presetn),
		.apb_req(req),
		.apb_resp(resp),
		.port_pins(port_pins),
		.port_out(port_out),
		.standby(standby),
		.watchdog_clear(watchdog_clear)
	);

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 30000) begin
			errors++;
			end_of_test;
		end
	end

	// answers stand one cycle, so the middle of the cycle sees each exactly once
	always @(negedge pclk) begin
		if (watchdog_clear === 1'b1) pulses++;
		if (resp.pready === 1'b1) begin
			nt = notes.pop_front();
			check("prdata", resp.prdata & nt.mask, nt.exp & nt.mask);
			check("pslverr", {31'h0, resp.pslverr}, {31'h0, nt.err});
		end
	end

	task automatic apb(input logic [7:0] ad, input logic dir, input logic [31:0] dat, input logic [31:0] exp,
			input logic [31:0] mask, input logic err);
		int n;
		n = 0;
		@(posedge pclk);
		notes.push_back('{exp, mask, err});
		req.paddr <= ad;
		req.pwrite <= dir;
		req.pwdata <= dat;
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		@(posedge pclk);
		req.penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (resp.pready !== 1'b1 && n < 50);
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] ad, input logic [31:0] exp, input logic [31:0] mask);
		apb(ad, 1'b0, 32'h0, exp, mask, 1'b0);
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] dat);
		apb(ad, 1'b1, dat, 32'h0, 32'h0, 1'b0);
	endtask

	task automatic chk_pc;
		rd(OFS_PROG_COUNTER, {19'h0, pc}, 32'h1FFF);
	endtask

	task automatic ex(input logic [13:0] word, input logic taken);
		wr(OFS_INSTR, {18'h0, word});
		rd(OFS_CORE_STATUS, 32'h1, 32'h1);
		repeat (16) @(posedge pclk);
		pc = pc + (taken ? PC_SKIP : PC_STEP);
	endtask

	task automatic setf(input logic [6:0] ad, input logic [7:0] v);
		ex({6'b110000, v}, 1'b0);
		ex({7'b0000001, ad}, 1'b0);
		w = v;
	endtask

	task automatic getf(input logic [6:0] ad, input logic [7:0] exp);
		ex({7'b0010000, ad}, 1'b0);
		fl[2] = exp == 8'h00;
		w = exp;
		rd(OFS_ACCUM, {24'h0, exp}, 32'hFF);
	endtask

	// reference result and flags; w and fl hold the model's accumulator and flags
	task automatic alu(input logic [3:0] o, input logic [7:0] f, output logic [7:0] res, output logic skip);
		case (o)
			OP_CLR: res = 8'h00;
			OP_SUB: res = f - w;
			OP_DEC, OP_DECSZ: res = f - 8'h01;
			OP_IOR: res = f | w;
			OP_AND: res = f & w;
			OP_XOR: res = f ^ w;
			OP_ADD: res = f + w;
			OP_MOV: res = f;
			OP_COM: res = ~f;
			OP_INC, OP_INCSZ: res = f + 8'h01;
			OP_RRC: res = {fl[0], f[7:1]};
			OP_RLC: res = {f[6:0], fl[0]};
			default: res = {f[3:0], f[7:4]};
		endcase
		skip = (o == OP_DECSZ || o == OP_INCSZ) && res == 8'h00;
		if (o == OP_ADD) fl = {res == 8'h00, ({1'b0, f[3:0]} + {1'b0, w[3:0]}) > 5'h0F, ({1'b0, f} + {1'b0, w}) > 9'h0FF};
		if (o == OP_SUB) fl = {res == 8'h00, f[3:0] >= w[3:0], f >= w};
		if (o == OP_RRC) fl[0] = f[0];
		if (o == OP_RLC) fl[0] = f[7];
		if (!(o inside {OP_ADD, OP_SUB, OP_RRC, OP_RLC, OP_SWAP, OP_DECSZ, OP_INCSZ})) fl[2] = res == 8'h00;
	endtask

	initial begin
		presetn = 1'b0;
		req = '0;
		port_pins = 8'h00;
		pc = 13'h0000;
		fl = 3'b000;
		w = 8'h00;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		check("port_out", {24'h0, port_out}, 32'h0);
		check("standby", {31'h0, standby}, 32'h0);
		rd(OFS_CORE_STATUS, 32'h1800, 32'hFF0F);
		rd(OFS_ACCUM, 32'h0, 32'hFF);
		chk_pc;
		$display("reset values done");
		// second half repeats every operation on boundary values to reach zero results and skips
		for (int i = 0; i < 32; i++) begin
			rn = $random(seed);
			op = (i[3:0] == OP_MISC) ? OP_ADD : i[3:0];
			// first add goes to the accumulator from the first general register so add_dest_a is reached
			d = (rn[0] && i != 0) | (op == OP_CLR);
			a = GPR_BASE + 7'((op == OP_ADD) ? 4'h0 : rn[4:1]);
			fv = (i < 16) ? rn[15:8] : ((op == OP_INCSZ) ? 8'hFF : 8'h01);
			setf(a, fv);
			w = rn[23:16];
			wr(OFS_ACCUM, {24'h0, w});
			alu(op, fv, r, tk);
			ex({2'b00, op, d, a}, tk);
			rd(OFS_CORE_STATUS, {21'h0, fl, 8'h00}, 32'h0700);
			rd(OFS_ACCUM, {24'h0, d ? w : r}, 32'hFF);
			chk_pc;
			getf(a, d ? r : fv);
		end
		$display("byte operations done");
		for (int i = 0; i < 8; i++) begin
			rn = $random(seed);
			// clears and sets hit the first general register so bit_rmw_a is reached
			a = GPR_BASE + 7'(i[2] ? rn[3:0] : 4'h0);
			fv = i[0] ? ~fv : rn[15:8];
			b = i[0] ? b : rn[6:4];
			c = i[2:1];
			setf(a, fv);
			tk = (c == 2'h2 && !fv[b]) || (c == 2'h3 && fv[b]);
			r = (c == 2'h0) ? (fv & ~(8'h01 << b)) : ((c == 2'h1) ? (fv | (8'h01 << b)) : fv);
			ex({2'b01, c, b, a}, tk);
			rd(OFS_CORE_STATUS, {21'h0, fl, 8'h00}, 32'h0700);
			chk_pc;
			getf(a, r);
		end
		$display("bit operations done");
		for (int i = 0; i < 9; i++) begin
			rn = $random(seed);
			b = fl;
			alu(lo[i], rn[7:0], r, tk);
			if (lo[i] == OP_MOV) fl = b;
			ex({lp[i], rn[7:0]}, 1'b0);
			rd(OFS_CORE_STATUS, {21'h0, fl, 8'h00}, 32'h0700);
			rd(OFS_ACCUM, {24'h0, r}, 32'hFF);
			w = r;
		end
		$display("literal operations done");
		ex(14'h0183, 1'b0);
		rd(OFS_CORE_STATUS, 32'h1C00, 32'hFF00);
		ex(WORD_CLEAR_ACCUM, 1'b0);
		rd(OFS_ACCUM, 32'h0, 32'hFF);
		ex(14'h0060, 1'b0);
		rd(OFS_CORE_STATUS, 32'h0, 32'h8);
		ex(14'h0001, 1'b0);
		rd(OFS_CORE_STATUS, 32'h8, 32'h8);
		for (int i = 0; i < 3; i++) begin
			ret = pc + PC_STEP;
			ex({3'b100, 11'h123 + 11'(i)}, 1'b0);
			pc = 13'h0123 + 13'(i);
			chk_pc;
			ex(rws[i], 1'b0);
			pc = ret;
			chk_pc;
		end
		rd(OFS_ACCUM, 32'h77, 32'hFF);
		rd(OFS_CORE_STATUS, 32'h4, 32'h4);
		$display("control words done");
		setf(ADDR_PC_HIGH_HOLDING_LATCH, 8'h0B);
		wr(OFS_ACCUM, 32'h40);
		ex({7'b0000001, ADDR_PCL}, 1'b0);
		pc = 13'h0B40;
		chk_pc;
		ex({6'b000111, 1'b1, ADDR_PCL}, 1'b0);
		rd(OFS_PROG_COUNTER, 32'h0B00, 32'h1F00);
		ex({3'b101, 11'h2AB}, 1'b0);
		pc = 13'h0AAB;
		chk_pc;
		$display("program counter done");
		rn = $random(seed);
		port_pins <= rn[7:0] & 8'h7E;
		setf(ADDR_PORT, 8'hFF);
		check("port_out", {24'h0, port_out}, 32'hFF);
		ex({6'b001000, 1'b1, ADDR_PORT}, 1'b0);
		check("port_out", {24'h0, port_out}, {24'h0, rn[7:0] & 8'h7E});
		ex({4'b0101, 3'h7, ADDR_PORT}, 1'b0);
		check("port_out", {24'h0, port_out}, {24'h0, (rn[7:0] & 8'h7E) | 8'h80});
		// a long wait lets the prescaler run high so that clearing it shows
		wr(OFS_TIMER_CFG, 32'h0F);
		repeat (600) @(posedge pclk);
		ex({7'b0000001, ADDR_TIMER_ZERO_COUNT}, 1'b0);
		rd(OFS_TIMER_CFG, 32'h0F, 32'h00C0000F);
		$display("port and timer done");
		ex(WORD_SLEEP, 1'b0);
		check("standby", {31'h0, standby}, 32'h1);
		rd(OFS_CORE_STATUS, 32'h1002, 32'h1802);
		ex(WORD_WATCHDOG_CLEAR, 1'b0);
		check("standby", {31'h0, standby}, 32'h0);
		rd(OFS_CORE_STATUS, 32'h1800, 32'h1802);
		check("watchdog pulses", pulses, 32'h1);
		chk_pc;
		$display("standby and watchdog done");
		wr(OFS_ACCUM, 32'h3C);
		apb(OFS_INSTR, 1'b1, {21'h0, 3'b101, 11'h000}, 32'h0, 32'h0, 1'b0);
		apb(OFS_ACCUM, 1'b1, 32'hA5, 32'h0, 32'h0, 1'b1);
		apb(OFS_INSTR, 1'b1, 32'h30A5, 32'h0, 32'h0, 1'b1);
		repeat (16) @(posedge pclk);
		pc = 13'h0800;
		chk_pc;
		rd(OFS_ACCUM, 32'h3C, 32'hFF);
		apb(8'h18, 1'b0, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
		apb(OFS_PROG_COUNTER, 1'b1, 32'h1ABC, 32'h0, 32'h0, 1'b0);
		chk_pc;
		$display("refusals done");
		repeat (4) @(posedge pclk);
		check("pending answers", notes.size(), 32'h0);
		end_of_test;
	end
endmodule
